/* File: core/uds_pkg.sv */
// constants, register map and types shared by the serial data path
package uds_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_CFG    = 32'h40064000;
  localparam logic [31:0] ADDR_CTL    = 32'h40064004;
  localparam logic [31:0] ADDR_STAT   = 32'h40064008;
  localparam logic [31:0] ADDR_IESET  = 32'h4006400C;
  localparam logic [31:0] ADDR_IECLR  = 32'h40064010;
  localparam logic [31:0] ADDR_RXDS   = 32'h40064018;
  localparam logic [31:0] ADDR_TXD    = 32'h4006401C;
  localparam logic [31:0] ADDR_BRG    = 32'h40064020;
  localparam logic [31:0] ADDR_MIS    = 32'h40064024;
  localparam logic [31:0] ADDR_FRAC   = 32'h40064030;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_EN_BIT   = 0;
  localparam int CFG_LEN_LSB  = 2;
  localparam int CFG_PAR_LSB  = 4;
  localparam int CFG_CTSG_BIT = 9;
  localparam int CTL_HALT_BIT = 6;
  localparam int CHAR_W       = 9;
  localparam int BRG_W        = 16;
  localparam int FRACTION_MULTIPLIER_W       = 8;
  localparam int STAT_W       = 17;
  localparam int RXDS_MISS    = 13;
  localparam int RXDS_PAR     = 14;
  localparam int RXDS_NOISE   = 15;

  localparam int ST_RX_CHAR_AVAILABLE  = 0;
  localparam int ST_TX_HOLDING_FREE  = 2;
  localparam int ST_TX_FULLY_IDLE = 3;
  localparam int ST_CTS    = 5;
  localparam int ST_TX_HALT_CTL  = 6;
  localparam int ST_OVR    = 8;
  localparam int ST_BRK    = 11;
  localparam int ST_START  = 12;
  localparam int ST_FRAME  = 13;
  localparam int ST_PARITY = 14;
  localparam int ST_NOISE  = 15;
  localparam int ST_AUTOBAUD_FAIL_FLAG  = 16;
  localparam logic [STAT_W-1:0] STICKY_MASK = 17'h1F920;

  // ----------------------------------------------------------------
  // bit-cell timing in oversample ticks
  // ----------------------------------------------------------------
  localparam logic [3:0] SMP_A        = 4'h7;
  localparam logic [3:0] SMP_B        = 4'h8;
  localparam logic [3:0] SMP_C        = 4'h9;
  localparam logic [3:0] BIT_LAST     = 4'hF;
  localparam logic [3:0] MIN_LAST_BIT = 4'h6;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } uds_rx_e;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP  = 3'b100
  } uds_tx_e;

endpackage : uds_pkg

/* File: core/uds_baud_if.sv */
// rate generator controls and oversample tick between core and divider
`timescale 1ns/100ps
interface uds_baud_if;
  logic                      enable;
  logic [uds_pkg::FRACTION_MULTIPLIER_W-1:0] fraction_multiplier;
  logic [uds_pkg::BRG_W-1:0]  div;
  logic                      tick;

  modport core (output enable, output fraction_multiplier, output div, input tick);
  modport gen  (input enable, input fraction_multiplier, input div, output tick);
endinterface : uds_baud_if

/* File: core/uds_baud_gen.sv */
// fractional clock suppressor followed by the integer baud divider
`timescale 1ns/100ps
module uds_baud_gen
  import uds_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  uds_baud_if.gen   bi
);

  typedef struct packed {
    logic [FRACTION_MULTIPLIER_W-1:0] acc;
    logic [BRG_W-1:0]  cnt;
    logic              owe;
    logic              tick;
  } uds_bg_s;

  uds_bg_s           s;
  uds_bg_s           next_s;
  logic [FRACTION_MULTIPLIER_W:0]   sum;
  logic              frg_pulse;

  // each accumulator overflow owes one swallowed input clock, paid on the next clock
  assign sum       = {1'b0, s.acc} + {1'b0, bi.fraction_multiplier};
  assign frg_pulse = bi.enable && !s.owe;
  assign bi.tick   = s.tick;

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (!bi.enable) begin
      next_s.acc = '0;
      next_s.owe = 1'b0;
      next_s.cnt = '0;
    end else if (frg_pulse) begin
      next_s.acc = sum[FRACTION_MULTIPLIER_W-1:0];
      next_s.owe = sum[FRACTION_MULTIPLIER_W];
      if (s.cnt == bi.div) begin
        next_s.cnt  = '0;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
      end
    end else begin
      next_s.owe = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  divider_wrap_a: assert property (@(posedge clk) disable iff (!nrst) s.tick |-> s.cnt == '0)
    else $error("divider did not restart after tick");
  pass_through_a: assert property (@(posedge clk) disable iff (!nrst)
      (bi.enable && bi.fraction_multiplier == '0 && bi.div == '0) ##1 (bi.enable && bi.fraction_multiplier == '0 && bi.div == '0)
      |=> s.tick)
    else $error("zero settings did not pass the clock through");

endmodule : uds_baud_gen

/* File: core/uds_top.sv */
// serial data path: receive data with status, transmit data, baud divider, masked status
//
// What this block does
// - next character and its error flags returned together in one 16-bit read
// - reading receive-data-with-status consumes the character and clears ready
// - received character sits in bits 8:0, width set by character length
// - bit 13 set when pending character had no stop bit
// - bit 14 set when pending character failed its parity check
// - bit 15 carries noise indication for the pending character
// - transmit data bits 8:0 move to shifter when free; then accept another
// - send only if transmit halt is 0 and, if gated, clear-to-send low
// - 16-bit divider divides fractional clock by value plus one
// - 16x oversampling, three centred samples per bit for noise detection
// - masked status view shows each status flag gated by its enable
// - start flag bit 12 set on detected start bit
// - clear-to-send change flag bit 5 set on any level change
// - break change flag bit 11 set when break detection toggles
// - masked status bit positions 0,2,3,5,6,8,11,12,13,14,15,16; others reserved zero
// - writing ones to enable-set register sets those enable bits only
// - writing ones to enable-clear register clears those enable bits only
// - fractional stage divides by one plus multiplier over 256 by suppression
`timescale 1ns/100ps
module uds_top
  import uds_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        cts_n,
  output logic             irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        rx_sync;
    logic [1:0]        cts_sync;
    logic              cts_prev;
    uds_rx_e           rx_st;
    logic [3:0]        rx_tick;
    logic [3:0]        rx_bit;
    logic [CHAR_W-1:0] rx_shift;
    logic [1:0]        rx_smp;
    logic              rx_noisy;
    logic              rx_par;
    logic [CHAR_W-1:0] rx_char;
    logic              miss_stop;
    logic              par_fail;
    logic              noise;
    logic              avail;
    logic              brk;
    uds_tx_e           tx_st;
    logic [3:0]        tx_tick;
    logic [3:0]        tx_bit;
    logic [CHAR_W-1:0] tx_hold;
    logic              hold_full;
    logic [CHAR_W-1:0] tx_shift;
    logic              tx_par;
    logic              txd;
    logic              enable;
    logic [1:0]        len;
    logic [1:0]        par_mode;
    logic              cts_gate;
    logic              halt;
    logic [BRG_W-1:0]  baud_divider;
    logic [FRACTION_MULTIPLIER_W-1:0] fraction_multiplier;
    logic [STAT_W-1:0] inten;
    logic [STAT_W-1:0] sticky;
    logic [31:0]       rdata;
  } uds_core_s;

  uds_core_s         s;
  uds_core_s         next_s;
  logic              line;
  logic              maj_bit;
  logic              all_same;
  logic [3:0]        last_bit;
  logic              rx_done;
  logic              tx_go;
  logic [STAT_W-1:0] set_ev;
  logic [STAT_W-1:0] clr_ev;
  logic [STAT_W-1:0] stat;
  logic [STAT_W-1:0] masked;

  uds_baud_if bi ();

  uds_baud_gen uds_baud_gen_inst (
    .clk  (clk),
    .nrst (nrst),
    .bi   (bi)
  );

  assign bi.enable = s.enable;
  assign bi.fraction_multiplier   = s.fraction_multiplier;
  assign bi.div    = s.baud_divider;

  // ----------------------------------------------------------------
  // status views
  // ----------------------------------------------------------------
  assign line     = s.rx_sync[1];
  assign maj_bit  = (s.rx_smp[1] & s.rx_smp[0]) | (s.rx_smp[1] & line) | (s.rx_smp[0] & line);
  assign all_same = (s.rx_smp[1] == s.rx_smp[0]) && (s.rx_smp[0] == line);
  assign last_bit = MIN_LAST_BIT + {2'b00, s.len};

  always_comb begin
    stat            = s.sticky & STICKY_MASK;
    stat[ST_RX_CHAR_AVAILABLE]  = s.avail;
    stat[ST_TX_HOLDING_FREE]  = !s.hold_full;
    stat[ST_TX_FULLY_IDLE] = (s.tx_st == TX_IDLE) && !s.hold_full;
    stat[ST_TX_HALT_CTL]  = s.halt && (s.tx_st == TX_IDLE);
  end

  assign masked = stat & s.inten;
  assign irq    = |masked;
  assign rdata  = s.rdata;
  assign txd    = s.txd;
  assign tx_go  = (s.tx_st == TX_IDLE) && s.hold_full && s.enable && !s.halt
                  && (!s.cts_gate || !s.cts_sync[1]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s          = s;
    set_ev          = '0;
    clr_ev          = '0;
    rx_done         = 1'b0;
    next_s.rdata    = '0;
    next_s.rx_sync  = {s.rx_sync[0], rxd};
    next_s.cts_sync = {s.cts_sync[0], cts_n};
    next_s.cts_prev = s.cts_sync[1];
    if (s.cts_sync[1] != s.cts_prev) begin
      set_ev[ST_CTS] = 1'b1;
    end

    if (wr) begin
      case (addr)
        ADDR_CFG: begin
          next_s.enable   = wdata[CFG_EN_BIT];
          next_s.len      = wdata[CFG_LEN_LSB +: 2];
          next_s.par_mode = wdata[CFG_PAR_LSB +: 2];
          next_s.cts_gate = wdata[CFG_CTSG_BIT];
        end
        ADDR_CTL:   next_s.halt  = wdata[CTL_HALT_BIT];
        ADDR_BRG:   next_s.baud_divider   = wdata[BRG_W-1:0];
        ADDR_FRAC:  next_s.fraction_multiplier  = wdata[FRACTION_MULTIPLIER_W-1:0];
        ADDR_IESET: next_s.inten = s.inten | wdata[STAT_W-1:0];
        ADDR_IECLR: next_s.inten = s.inten & ~wdata[STAT_W-1:0];
        ADDR_STAT:  clr_ev       = wdata[STAT_W-1:0] & STICKY_MASK;
        ADDR_TXD: begin
          // a write while the holding register is full is dropped
          if (!s.hold_full) begin
            next_s.tx_hold   = wdata[CHAR_W-1:0];
            next_s.hold_full = 1'b1;
          end
        end
        default: ;
      endcase
    end

    if (rd) begin
      case (addr)
        ADDR_RXDS: begin
          next_s.rdata = {16'h0000, s.noise, s.par_fail, s.miss_stop, 4'h0, s.rx_char};
          next_s.avail = 1'b0;
        end
        ADDR_CFG:   next_s.rdata = {22'h000000, s.cts_gate, 3'h0, s.par_mode, s.len, 1'b0, s.enable};
        ADDR_CTL:   next_s.rdata = {25'h0000000, s.halt, 6'h00};
        ADDR_STAT:  next_s.rdata = {15'h0000, stat};
        ADDR_IESET: next_s.rdata = {15'h0000, s.inten};
        ADDR_BRG:   next_s.rdata = {16'h0000, s.baud_divider};
        ADDR_MIS:   next_s.rdata = {15'h0000, masked};
        ADDR_FRAC:  next_s.rdata = {24'h000000, s.fraction_multiplier};
        default:    next_s.rdata = '0;
      endcase
    end

    // receiver: start on low line, three samples centred in each cell
    if (!s.enable) begin
      next_s.rx_st = RX_IDLE;
    end else if (s.rx_st == RX_IDLE) begin
      // a held break must end before a new start is accepted
      if (!line && !s.brk) begin
        next_s.rx_st    = RX_START;
        next_s.rx_tick  = '0;
        next_s.rx_bit   = '0;
        next_s.rx_shift = '0;
        next_s.rx_par   = 1'b0;
        next_s.rx_noisy = 1'b0;
        set_ev[ST_START] = 1'b1;
      end
    end else if (bi.tick) begin
      next_s.rx_tick = s.rx_tick + 4'h1;
      if (s.rx_tick == SMP_A || s.rx_tick == SMP_B) begin
        next_s.rx_smp = {s.rx_smp[0], line};
      end
      if (s.rx_tick == SMP_C) begin
        next_s.rx_noisy = s.rx_noisy | !all_same;
        case (s.rx_st)
          RX_START: begin
            if (maj_bit) begin
              next_s.rx_st = RX_IDLE;
            end
          end
          RX_DATA: begin
            next_s.rx_shift[s.rx_bit] = maj_bit;
            next_s.rx_par             = s.rx_par ^ maj_bit;
          end
          RX_PAR:  next_s.rx_par = s.rx_par ^ maj_bit;
          RX_STOP: begin
            rx_done      = 1'b1;
            next_s.rx_st = RX_IDLE;
          end
          default: next_s.rx_st = RX_IDLE;
        endcase
      end
      if (s.rx_tick == BIT_LAST) begin
        case (s.rx_st)
          RX_START: next_s.rx_st = RX_DATA;
          RX_DATA: begin
            if (s.rx_bit == last_bit) begin
              next_s.rx_st = s.par_mode[1] ? RX_PAR : RX_STOP;
            end else begin
              next_s.rx_bit = s.rx_bit + 4'h1;
            end
          end
          RX_PAR:  next_s.rx_st = RX_STOP;
          default: next_s.rx_st = RX_IDLE;
        endcase
      end
    end

    if (rx_done) begin
      if (!maj_bit) begin
        set_ev[ST_FRAME] = 1'b1;
      end
      if (s.par_mode[1] && (s.rx_par ^ s.par_mode[0])) begin
        set_ev[ST_PARITY] = 1'b1;
      end
      if (next_s.rx_noisy) begin
        set_ev[ST_NOISE] = 1'b1;
      end
      if (!maj_bit && s.rx_shift == '0) begin
        next_s.brk = 1'b1;
      end
      // an unread character is kept; the newcomer is lost
      if (next_s.avail) begin
        set_ev[ST_OVR] = 1'b1;
      end else begin
        next_s.rx_char   = s.rx_shift;
        next_s.miss_stop = !maj_bit;
        next_s.par_fail  = s.par_mode[1] & (s.rx_par ^ s.par_mode[0]);
        next_s.noise     = next_s.rx_noisy;
        next_s.avail     = 1'b1;
      end
    end else if (s.brk && line) begin
      next_s.brk = 1'b0;
    end
    if (next_s.brk != s.brk) begin
      set_ev[ST_BRK] = 1'b1;
    end

    // transmitter: one bit cell per sixteen ticks
    if (!s.enable) begin
      next_s.tx_st = TX_IDLE;
      next_s.txd   = 1'b1;
    end else if (tx_go) begin
      next_s.tx_shift  = s.tx_hold;
      next_s.hold_full = 1'b0;
      next_s.tx_st     = TX_START;
      next_s.tx_tick   = '0;
      next_s.tx_bit    = '0;
      next_s.tx_par    = s.par_mode[0];
      next_s.txd       = 1'b0;
    end else if (bi.tick && s.tx_st != TX_IDLE) begin
      next_s.tx_tick = s.tx_tick + 4'h1;
      if (s.tx_tick == BIT_LAST) begin
        case (s.tx_st)
          TX_START: begin
            next_s.tx_st = TX_DATA;
            next_s.txd   = s.tx_shift[0];
          end
          TX_DATA: begin
            next_s.tx_par   = s.tx_par ^ s.tx_shift[0];
            next_s.tx_shift = s.tx_shift >> 1;
            if (s.tx_bit == last_bit) begin
              next_s.tx_st = s.par_mode[1] ? TX_PAR : TX_STOP;
              next_s.txd   = s.par_mode[1] ? (s.tx_par ^ s.tx_shift[0]) : 1'b1;
            end else begin
              next_s.tx_bit = s.tx_bit + 4'h1;
              next_s.txd    = s.tx_shift[1];
            end
          end
          TX_PAR: begin
            next_s.tx_st = TX_STOP;
            next_s.txd   = 1'b1;
          end
          default: begin
            next_s.tx_st = TX_IDLE;
            next_s.txd   = 1'b1;
          end
        endcase
      end
    end

    // a new event outlasts a same-cycle clear
    next_s.sticky = ((s.sticky & ~clr_ev) | set_ev) & STICKY_MASK;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      // synchronisers start at the idle line levels so no false edge follows reset
      s          <= '0;
      s.txd      <= 1'b1;
      s.rx_sync  <= 2'h3;
      s.cts_sync <= 2'h3;
      s.cts_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  consume_read_a: assert property (@(posedge clk) disable iff (!nrst)
      (rd && addr == ADDR_RXDS && !rx_done) |=> !s.avail)
    else $error("read of receive data did not consume character");
  status_read_a: assert property (@(posedge clk) disable iff (!nrst)
      (rd && addr == ADDR_RXDS) |=> (rdata[RXDS_MISS] == $past(s.miss_stop)
      && rdata[RXDS_NOISE] == $past(s.noise) && rdata[CHAR_W-1:0] == $past(s.rx_char)))
    else $error("receive status read returned wrong fields");
  tx_gate_a: assert property (@(posedge clk) disable iff (!nrst)
      (s.tx_st == TX_IDLE && next_s.tx_st == TX_START) |-> (!s.halt && (!s.cts_gate || !s.cts_sync[1])))
    else $error("transmit started while blocked");
  enable_set_a: assert property (@(posedge clk) disable iff (!nrst)
      (wr && addr == ADDR_IESET) |=> (s.inten == ($past(s.inten) | $past(wdata[STAT_W-1:0]))))
    else $error("enable set write wrong");
  enable_clear_a: assert property (@(posedge clk) disable iff (!nrst)
      (wr && addr == ADDR_IECLR) |=> (s.inten & $past(wdata[STAT_W-1:0])) == '0)
    else $error("enable clear write left bits set");
  cts_change_a: assert property (@(posedge clk) disable iff (!nrst)
      $changed(s.cts_sync[1]) |=> s.sticky[ST_CTS])
    else $error("clear-to-send change not flagged");
  start_flag_a: assert property (@(posedge clk) disable iff (!nrst)
      (s.rx_st == RX_IDLE && next_s.rx_st == RX_START) |=> s.sticky[ST_START])
    else $error("start detect not flagged");
  set_wins_a: assert property (@(posedge clk) disable iff (!nrst)
      (set_ev[ST_OVR] && clr_ev[ST_OVR]) |=> s.sticky[ST_OVR])
    else $error("overrun lost to clear");
  masked_read_a: assert property (@(posedge clk) disable iff (!nrst)
      (rd && addr == ADDR_MIS) |=> (rdata[31:STAT_W] == '0 && rdata[1] == 1'b0
      && rdata[STAT_W-1:0] == ($past(stat) & $past(s.inten))))
    else $error("masked status read wrong");
  irq_level_a: assert property (@(posedge clk) disable iff (!nrst)
      (s.inten[ST_TX_HOLDING_FREE] && !s.hold_full) |-> irq)
    else $error("interrupt low with enabled flag set");

endmodule : uds_top

/* File: tb/uds_line_model.sv */
// behavioural remote serial device on the line side
`timescale 1ns/100ps
module uds_line_model (
  input  wire logic clk,
  output logic      rxd,
  input  wire logic txd,
  output logic      cts_n
);
  initial begin
    rxd   = 1'b1;
    cts_n = 1'b1;
  end

  task automatic set_cts(input logic v);
    @(posedge clk);
    cts_n <= v;
  endtask : set_cts

  // start, data lsb first, parity bit if pb >= 0, one stop; g puts a one-clock glitch mid bit 0
  task automatic send(input logic [8:0] d, input int n, input int pb, input bit stop, input bit g, input int cpb);
    logic b;
    for (int i = 0; i < n + 2 + (pb >= 0); i++) begin
      b = (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : (pb >= 0 && i == n + 1) ? pb[0] : stop;
      for (int j = 0; j < cpb; j++) begin
        @(posedge clk);
        rxd <= b ^ (g && i == 1 && j == 8);
      end
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask : send

  // mid-cell sampling of one frame; gives up after lim clocks without a start
  task automatic recv(input int n, input int cpb, input int lim, output logic [8:0] d, output logic s, output bit seen);
    seen = 1'b0;
    d    = '0;
    s    = 1'b0;
    for (int t = 0; t < lim && !seen; t++) begin
      @(posedge clk);
      seen = (txd === 1'b0);
    end
    if (seen) begin
      repeat (cpb / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
        repeat (cpb) @(posedge clk);
        d[i] = txd;
      end
      repeat (cpb) @(posedge clk);
      s = txd;
    end
  endtask : recv
endmodule : uds_line_model

/* File: tb/uds_top_tb.sv */
// self-checking bench for the serial data path registers and line side
`timescale 1ns/100ps
module uds_top_tb
  import uds_pkg::*;
();
  localparam logic [31:0] DIV_ADDR = 32'h40064020;
  logic        clk;
  logic        nrst;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        rxd;
  logic        txd;
  logic        cts_n;
  logic        irq;
  int          fail_count;
  int          comparisons;

  uds_top uds_top_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxd(rxd), .txd(txd), .cts_n(cts_n), .irq(irq));
  uds_line_model uds_line_model_inst (.clk(clk), .rxd(rxd), .txd(txd), .cts_n(cts_n));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // bus cycles and compares
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_w

  task automatic chk_b(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_b

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    rd_reg(a, v);
    chk_w(nm, e, v);
  endtask : rd_chk

  task automatic rd_bit(input int b, input logic e, input string nm);
    logic [31:0] v;
    rd_reg(ADDR_STAT, v);
    chk_b(nm, e, v[b]);
  endtask : rd_bit

  task automatic rx_char(input logic [8:0] d, input int pb, input bit stop, input bit g, input logic [31:0] e);
    logic [31:0] v;
    wr_reg(ADDR_STAT, 32'h0001FFFF);
    uds_line_model_inst.send(d, 8, pb, stop, g, 16);
    for (int i = 0; i < 40; i++) begin
      rd_reg(ADDR_STAT, v);
      if (v[ST_RX_CHAR_AVAILABLE] === 1'b1) break;
    end
    rd_chk(ADDR_RXDS, e, "rx_data_with_status");
  endtask : rx_char

  task automatic tx_expect(input int cpb, input logic [8:0] e, input bit sn);
    logic [8:0] d;
    logic       s;
    bit         seen;
    uds_line_model_inst.recv(8, cpb, sn ? 4000 : 300, d, s, seen);
    chk_b("tx frame started", sn, seen);
    if (sn) begin
      chk_w("tx_character", {23'h0, e}, {23'h0, d});
      chk_b("tx stop level", 1'b1, s);
    end
  endtask : tx_expect

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(DIV_ADDR, 32'h0, "baud_divider");
    rd_chk(ADDR_MIS, 32'h0, "masked_irq_status");
    rd_chk(32'h40064050, 32'h0, "unmapped read");
    chk_b("irq", 1'b0, irq);
  endtask : t_reset

  task automatic t_enables();
    wr_reg(ADDR_CFG, 32'h5);
    wr_reg(ADDR_IESET, 32'h0001000C);
    rd_chk(ADDR_IESET, 32'h0001000C, "irq_enable_set");
    rd_chk(ADDR_MIS, 32'hC, "masked_irq_status");
    wr_reg(ADDR_IECLR, 32'h00010008);
    rd_chk(ADDR_IESET, 32'h4, "irq_enable_clear");
    rd_chk(ADDR_MIS, 32'h4, "masked_irq_status");
    chk_b("irq", 1'b1, irq);
    wr_reg(ADDR_IECLR, 32'hFFFFFFFF);
    rd_chk(ADDR_MIS, 32'h0, "masked_irq_status");
    chk_b("irq", 1'b0, irq);
  endtask : t_enables

  task automatic t_rx();
    logic [31:0] v;
    rx_char(9'h0A5, -1, 1'b1, 1'b0, 32'h00A5);
    rd_bit(ST_RX_CHAR_AVAILABLE, 1'b0, "rx_char_available");
    rd_bit(ST_START, 1'b1, "start flag");
    rx_char(9'h0FF, -1, 1'b1, 1'b1, 32'h80FF);
    rx_char(9'h055, -1, 1'b0, 1'b0, 32'h2055);
    wr_reg(ADDR_CFG, 32'h25);
    rx_char(9'h003, 1, 1'b1, 1'b0, 32'h4003);
    rx_char(9'h007, 1, 1'b1, 1'b0, 32'h0007);
    wr_reg(ADDR_CFG, 32'h35);
    rx_char(9'h003, 1, 1'b1, 1'b0, 32'h0003);
    wr_reg(ADDR_CFG, 32'h5);
    wr_reg(ADDR_STAT, 32'h0001FFFF);
    uds_line_model_inst.send(9'h000, 8, -1, 1'b0, 1'b0, 16);
    rd_bit(ST_BRK, 1'b1, "break_state_changed");
    rd_reg(ADDR_RXDS, v);
  endtask : t_rx

  // second character arrives unread; an overrun clear in that very cycle must lose
  task automatic t_overrun();
    wr_reg(ADDR_STAT, 32'h0001FFFF);
    uds_line_model_inst.send(9'h011, 8, -1, 1'b1, 1'b0, 16);
    fork
      uds_line_model_inst.send(9'h022, 8, -1, 1'b1, 1'b0, 16);
      begin
        // stop-bit decision of the second frame lands 157 edges after its start edge
        repeat (156) @(posedge clk);
        wr_reg(ADDR_STAT, 32'h00000100);
      end
    join
    rd_bit(ST_OVR, 1'b1, "rx_overrun_flag");
    rd_chk(ADDR_RXDS, 32'h00000011, "rx_data_with_status");
  endtask : t_overrun

  task automatic t_tx();
    wr_reg(ADDR_CTL, 32'h40);
    wr_reg(ADDR_TXD, 32'h3C);
    tx_expect(16, 9'h03C, 1'b0);
    rd_bit(ST_TX_HALT_CTL, 1'b1, "tx_disabled_flag");
    wr_reg(ADDR_CTL, 32'h0);
    tx_expect(16, 9'h03C, 1'b1);
    wr_reg(ADDR_CFG, 32'h205);
    wr_reg(ADDR_STAT, 32'h0001FFFF);
    wr_reg(ADDR_TXD, 32'h5A);
    tx_expect(16, 9'h05A, 1'b0);
    uds_line_model_inst.set_cts(1'b0);
    tx_expect(16, 9'h05A, 1'b1);
    rd_bit(ST_CTS, 1'b1, "cts_changed");
    wr_reg(ADDR_CFG, 32'h5);
  endtask : t_tx

  // divider is only rewritten with the block disabled
  task automatic t_baud();
    wr_reg(ADDR_CFG, 32'h0);
    wr_reg(DIV_ADDR, 32'h1);
    rd_chk(DIV_ADDR, 32'h1, "baud_divider");
    wr_reg(ADDR_CFG, 32'h5);
    fork
      begin
        wr_reg(ADDR_TXD, 32'hC3);
        wr_reg(ADDR_TXD, 32'h81);
      end
      begin
        tx_expect(32, 9'h0C3, 1'b1);
        tx_expect(32, 9'h081, 1'b1);
      end
    join
    wr_reg(ADDR_CFG, 32'h0);
    wr_reg(DIV_ADDR, 32'h0);
    wr_reg(ADDR_FRAC, 32'h80);
    wr_reg(ADDR_CFG, 32'h5);
    wr_reg(ADDR_TXD, 32'h96);
    tx_expect(24, 9'h096, 1'b1);
  endtask : t_baud

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    nrst  = 1'b0;
    addr  = '0;
    wdata = '0;
    wr    = 1'b0;
    rd    = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_enables();
    t_rx();
    t_overrun();
    t_tx();
    t_baud();
    conclude();
  end

  // whole run needs about 3.5k cycles; allow far more
  initial begin
    #400000;
    fail_count++;
    conclude();
  end
endmodule : uds_top_tb
